// >>> design/pare_defines.vh
// pare_defines.vh: constants for the physical address router and encryption tagger
// assumes: included by bare name from the design files, definitions only
`ifndef PARE_DEFINES_VH
`define PARE_DEFINES_VH

// ceiling register address field
`define PARE_CEIL_MSB 51
`define PARE_CEIL_LSB 23
// system configuration bits
`define PARE_CFG_LOW_EN 20
`define PARE_CFG_HIGH_EN 21
`define PARE_CFG_SK_EN 23
`define PARE_CFG_MK_EN 26
// 4 GB boundary as a 52-bit address
`define PARE_FOUR_GB 52'h0_0001_0000_0000
// reset values
`define PARE_CEIL_RST 64'h0000_0000_0000_0000
`define PARE_CFG_RST 64'h0000_0000_0000_0000
// extended type field positions
`define PARE_TYPE_WR 3
`define PARE_TYPE_RD 4
// register select codes on the configuration port
`define PARE_SEL_LOW 2'h0
`define PARE_SEL_HIGH 2'h1
`define PARE_SEL_CFG 2'h2
// key generator seed, arbitrary value
`define PARE_KEY_SEED 32'hA5C3_0F1E

`endif

// >>> design/pare_key_gen.v
// pare_key_gen.v: free-running lfsr that yields a per-boot random key
// assumes: one clock, async active-low reset; entropy comes from boot timing
`timescale 1ns/1ps
`default_nettype none
`include "pare_defines.vh"

module pare_key_gen #(
    parameter W = 32
) (
    input wire clk_i,
    input wire nrst_i,
    input wire capture_i,
    output reg [W-1:0] key_o,
    output reg key_valid_o
);
    reg [W-1:0] lfsr_reg; // running shift state

    // lfsr advances every cycle, key latched once
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            lfsr_reg <= `PARE_KEY_SEED;
            key_o <= {W{1'b0}};
            key_valid_o <= 1'b0;
        end else begin
            lfsr_reg <= {lfsr_reg[W-2:0], lfsr_reg[W-1] ^ lfsr_reg[W-2] ^ lfsr_reg[0]};
            if (capture_i && !key_valid_o) begin
                key_o <= lfsr_reg;
                key_valid_o <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// >>> design/pare_top.v
// pare_top.v: physical address routing and memory encryption attribute logic
// assumes: core drives request address/attributes on MCLK_I; config writes arrive
// on a simple write/read select port; cipher engine sits downstream
// Notes on behaviour
// R01 - below ceilings, low or above 4G: memory
// R02 - ceiling up to 4G/top: memory-mapped I/O
// R03 - ceilings hold bits 51..23, 8MB granular
// R04 - other ceiling bits ignored by hardware
// R05 - low ceiling used only when bit 20
// R06 - high ceiling used only when bit 21
// R07 - disabled ceiling sends accesses to I/O
// R08 - merge read/write routing with memory type
// R09 - encrypted pages decrypt on read, encrypt write
// R10 - one random boot key, never software visible
// R11 - single-key needs config bit 23 set
// R12 - encryption needs PAE and paging enabled
// R13 - nonzero removed address bits raise page fault
// R14 - encrypt attribute set means page encrypted
// R15 - encrypted upper entry: next table decrypted
// R16 - range checks use masked reduced address
// R17 - encrypted access to I/O is ignored
// R18 - flush before toggling unless coherency bit
// R19 - toggling attribute never re-encrypts contents
// R20 - legacy 32-bit: first table kept plain
// R21 - multi-key when bit 26 set, 23 clear
// R22 - key index field ends at encrypt bit
// R23 - routing decided same cycle as request
`timescale 1ns/1ps
`default_nettype none
`include "pare_defines.vh"

module pare_top #(
    parameter PA_W = 52, // architectural physical address width
    parameter RED_W = 43, // reduced address width while encryption on
    parameter CBIT_POS = 47, // encrypt attribute bit position
    parameter KID_W = 4, // key index width, log2(max index + 1)
    parameter KEY_W = 32, // width of boot key
    parameter COHERENT = 1'b0 // cross-domain coherency capability
) (
    input wire MCLK_I,
    input wire NRST_I,
    // configuration port
    input wire CFG_WE_I,
    input wire [1:0] CFG_SEL_I,
    input wire [63:0] CFG_WDATA_I,
    output reg [63:0] CFG_RDATA_O,
    // processor mode
    input wire PAE_I,
    input wire PAGING_I,
    // request from core
    input wire REQ_VALID_I,
    input wire REQ_WRITE_I,
    input wire REQ_WALK_I,
    input wire REQ_ENC_I,
    input wire [63:0] REQ_ADDR_I,
    input wire [2:0] MTYPE_I,
    input wire FIX_RD_MEM_I,
    input wire FIX_WR_MEM_I,
    input wire FIX_HIT_I,
    // routed request outputs
    output reg OUT_VALID_O,
    output reg OUT_WRITE_O,
    output reg OUT_TO_DRAM_O,
    output reg OUT_CRYPT_O,
    output reg [KID_W-1:0] OUT_KEY_INDEX_O,
    output reg [PA_W-1:0] OUT_ADDR_O,
    output reg [4:0] OUT_TYPE_O,
    output reg OUT_DROP_O,
    output reg OUT_FAULT_O,
    output reg OUT_NEXT_DECRYPT_O,
    output reg [KEY_W-1:0] OUT_KEY_O,
    output reg COHERENT_O
);
    // software-visible registers
    reg [63:0] low_memory_ceiling_reg;
    reg [63:0] high_memory_ceiling_reg;
    reg [63:0] system_config_register_reg;
    wire [KEY_W-1:0] boot_key; // hidden key, not on read path
    wire boot_key_valid;

    // config enables
    wire low_ceiling_enable = system_config_register_reg[`PARE_CFG_LOW_EN];
    wire high_ceiling_enable = system_config_register_reg[`PARE_CFG_HIGH_EN];
    wire single_key_encrypt_enable = system_config_register_reg[`PARE_CFG_SK_EN];
    wire multi_key_encrypt_enable = system_config_register_reg[`PARE_CFG_MK_EN];

    // config write, ceilings store the whole written word; only bits 51..23 are compared
    always @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            low_memory_ceiling_reg <= `PARE_CEIL_RST;
            high_memory_ceiling_reg <= `PARE_CEIL_RST;
            system_config_register_reg <= `PARE_CFG_RST;
        end else if (CFG_WE_I) begin
            case (CFG_SEL_I)
                `PARE_SEL_LOW: begin
                    low_memory_ceiling_reg <= CFG_WDATA_I; // R03
                end
                `PARE_SEL_HIGH: begin
                    high_memory_ceiling_reg <= CFG_WDATA_I; // R03
                end
                `PARE_SEL_CFG: begin
                    system_config_register_reg <= CFG_WDATA_I;
                end
                default: begin
                    system_config_register_reg <= system_config_register_reg;
                end
            endcase
        end
    end

    // read back, registered; boot key never selectable
    always @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            CFG_RDATA_O <= 64'h0000_0000_0000_0000;
        end else begin
            case (CFG_SEL_I)
                `PARE_SEL_LOW: CFG_RDATA_O <= low_memory_ceiling_reg;
                `PARE_SEL_HIGH: CFG_RDATA_O <= high_memory_ceiling_reg;
                `PARE_SEL_CFG: CFG_RDATA_O <= system_config_register_reg;
                default: CFG_RDATA_O <= 64'h0000_0000_0000_0000; // R10
            endcase
        end
    end

    // boot key source
    pare_key_gen #(
        .W(KEY_W)
    ) u_key (
        .clk_i(MCLK_I),
        .nrst_i(NRST_I),
        .capture_i(single_key_encrypt_enable),
        .key_o(boot_key),
        .key_valid_o(boot_key_valid)
    );

    // encryption modes
    wire paging_ok = PAE_I && PAGING_I; // R12
    wire sk_mode = single_key_encrypt_enable; // R11
    wire mk_mode = multi_key_encrypt_enable && !single_key_encrypt_enable; // R21
    wire enc_on = (sk_mode || mk_mode) && paging_ok;

    // address masking and reduced-size checks
    reg [PA_W-1:0] range_addr; // address used for range checks
    reg upper_nonzero; // removed bits carry a one
    reg [KID_W-1:0] key_index; // key index from upper bits
    reg enc_attr; // page encrypt attribute
    integer i;
    always @* begin
        range_addr = REQ_ADDR_I[PA_W-1:0];
        upper_nonzero = 1'b0;
        key_index = {KID_W{1'b0}};
        enc_attr = 1'b0;
        if (enc_on) begin
            for (i = RED_W; i < PA_W; i = i + 1) begin
                range_addr[i] = 1'b0; // R16
            end
            if (mk_mode) begin
                key_index = REQ_ADDR_I[CBIT_POS -: KID_W]; // R22
                enc_attr = (key_index != {KID_W{1'b0}}); // R22
                for (i = RED_W; i < PA_W; i = i + 1) begin
                    if (REQ_ADDR_I[i] && (i > CBIT_POS || i <= CBIT_POS - KID_W)) begin
                        upper_nonzero = 1'b1; // R13
                    end
                end
            end else begin
                enc_attr = REQ_ENC_I; // R14
                for (i = RED_W; i < PA_W; i = i + 1) begin
                    if (REQ_ADDR_I[i] && i != CBIT_POS) begin
                        upper_nonzero = 1'b1; // R13
                    end
                end
            end
        end
    end

    // ceiling comparisons on the masked address
    wire [PA_W-1:0] low_ceil = {low_memory_ceiling_reg[`PARE_CEIL_MSB:`PARE_CEIL_LSB],
        23'h00_0000}; // R04
    wire [PA_W-1:0] high_ceil = {high_memory_ceiling_reg[`PARE_CEIL_MSB:`PARE_CEIL_LSB],
        23'h00_0000}; // R04
    wire below_4g = range_addr < `PARE_FOUR_GB;
    wire in_low_mem = low_ceiling_enable && below_4g && (range_addr < low_ceil); // R01 R05
    wire in_high_mem = high_ceiling_enable && !below_4g && (range_addr < high_ceil); // R01 R06
    wire ceil_dram = in_low_mem || in_high_mem; // R02 R07

    // merge with extended fixed-range encoding
    reg rd_mem;
    reg wr_mem;
    always @* begin
        if (FIX_HIT_I) begin
            rd_mem = FIX_RD_MEM_I; // R08
            wr_mem = FIX_WR_MEM_I; // R08
        end else begin
            rd_mem = ceil_dram;
            wr_mem = ceil_dram;
        end
    end
    wire to_dram = REQ_WRITE_I ? wr_mem : rd_mem;

    // request outcome, decided from this cycle's address
    wire drop = enc_attr && !to_dram; // R17
    wire crypt = enc_on && enc_attr && to_dram; // R09 R19

    // registered request outputs
    always @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            OUT_VALID_O <= 1'b0;
            OUT_WRITE_O <= 1'b0;
            OUT_TO_DRAM_O <= 1'b0;
            OUT_CRYPT_O <= 1'b0;
            OUT_KEY_INDEX_O <= {KID_W{1'b0}};
            OUT_ADDR_O <= {PA_W{1'b0}};
            OUT_TYPE_O <= 5'h00;
            OUT_DROP_O <= 1'b0;
            OUT_FAULT_O <= 1'b0;
            OUT_NEXT_DECRYPT_O <= 1'b0;
        end else begin
            // R23
            OUT_VALID_O <= REQ_VALID_I && !drop && !(REQ_WALK_I && upper_nonzero);
            OUT_WRITE_O <= REQ_WRITE_I;
            OUT_TO_DRAM_O <= to_dram;
            OUT_CRYPT_O <= crypt;
            OUT_KEY_INDEX_O <= crypt ? key_index : {KID_W{1'b0}};
            OUT_ADDR_O <= range_addr;
            OUT_TYPE_O <= {rd_mem, wr_mem, MTYPE_I}; // R08
            OUT_DROP_O <= REQ_VALID_I && drop;
            OUT_FAULT_O <= REQ_VALID_I && REQ_WALK_I && upper_nonzero; // R13
            OUT_NEXT_DECRYPT_O <= REQ_VALID_I && REQ_WALK_I && crypt; // R15
        end
    end

    // key to cipher, only once single-key mode is up
    always @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            OUT_KEY_O <= {KEY_W{1'b0}};
            COHERENT_O <= 1'b0;
        end else begin
            OUT_KEY_O <= (sk_mode && boot_key_valid) ? boot_key : {KEY_W{1'b0}}; // R10
            COHERENT_O <= COHERENT; // R18
        end
    end
endmodule
`default_nettype wire

// >>> verification/pare_chk_assertions.sv
// pare_chk_assertions.sv: port-level checker for the address router
// assumes: bound into pare_top; low ceiling and system config shadowed from the write port
`timescale 1ns/1ps
`default_nettype none
module pare_chk #(
    parameter RED_W = 43,
    parameter CBIT_POS = 47,
    parameter KID_W = 4
) (
    input wire logic MCLK_I,
    input wire logic NRST_I,
    input wire logic CFG_WE_I,
    input wire logic [1:0] CFG_SEL_I,
    input wire logic [63:0] CFG_WDATA_I,
    input wire logic [63:0] CFG_RDATA_O,
    input wire logic PAE_I,
    input wire logic PAGING_I,
    input wire logic REQ_VALID_I,
    input wire logic REQ_WALK_I,
    input wire logic [63:0] REQ_ADDR_I,
    input wire logic FIX_HIT_I,
    input wire logic OUT_VALID_O,
    input wire logic OUT_TO_DRAM_O,
    input wire logic OUT_CRYPT_O,
    input wire logic [KID_W-1:0] OUT_KEY_INDEX_O,
    input wire logic OUT_DROP_O,
    input wire logic OUT_FAULT_O
);
    logic [63:0] lo_q; // shadow low ceiling
    logic [63:0] cf_q; // shadow system config
    // mirror config writes so routing can be predicted
    always @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            lo_q <= 64'h0;
            cf_q <= 64'h0;
        end else if (CFG_WE_I && CFG_SEL_I == 2'h0) begin
            lo_q <= CFG_WDATA_I;
        end else if (CFG_WE_I && CFG_SEL_I == 2'h2) begin
            cf_q <= CFG_WDATA_I;
        end
    end
    wire logic en = PAE_I & PAGING_I; // paging mode allows cipher
    wire logic rq = REQ_VALID_I & ~FIX_HIT_I; // request left to ceilings
    wire logic lo4 = REQ_ADDR_I[51:32] == 20'h0; // below 4 GB
    wire logic below = REQ_ADDR_I[51:23] < lo_q[51:23]; // under low ceiling
    wire logic [KID_W-1:0] kid = REQ_ADDR_I[CBIT_POS -: KID_W]; // key field
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!NRST_I);
    cfg_read_a: assert property (!CFG_WE_I && CFG_SEL_I == 2'h0 |=> CFG_RDATA_O == $past(lo_q))
        else $error("ceiling read back differs");
    low_off_io_a: assert property (rq && lo4 && !cf_q[20] |=> !OUT_TO_DRAM_O)
        else $error("disabled ceiling routed to dram");
    low_mem_a: assert property (rq && lo4 && cf_q[20] && below |=> OUT_TO_DRAM_O)
        else $error("low memory not routed to dram");
    low_io_a: assert property (rq && lo4 && cf_q[20] && !below |=> !OUT_TO_DRAM_O)
        else $error("low hole not routed to io");
    drop_io_a: assert property (OUT_DROP_O |-> !OUT_VALID_O && !OUT_TO_DRAM_O && $past(REQ_VALID_I))
        else $error("drop without io request");
    plain_mode_a: assert property (REQ_VALID_I && !en |=> !OUT_CRYPT_O)
        else $error("cipher on without paging");
    walk_fault_a: assert property (REQ_VALID_I && REQ_WALK_I && cf_q[23] && en
        && REQ_ADDR_I[CBIT_POS-1:RED_W] != 0 |=> OUT_FAULT_O && !OUT_VALID_O)
        else $error("walk with removed bits not faulted");
    key_index_a: assert property (REQ_VALID_I && cf_q[26] && !cf_q[23] && en |=> !OUT_VALID_O
        || (OUT_KEY_INDEX_O == $past(kid) && OUT_CRYPT_O == ($past(kid) != 0)))
        else $error("key index wrong");
endmodule
bind pare_top pare_chk #(.RED_W(RED_W), .CBIT_POS(CBIT_POS), .KID_W(KID_W)) pare_chk_inst (
    .MCLK_I(MCLK_I), .NRST_I(NRST_I), .CFG_WE_I(CFG_WE_I), .CFG_SEL_I(CFG_SEL_I),
    .CFG_WDATA_I(CFG_WDATA_I), .CFG_RDATA_O(CFG_RDATA_O), .PAE_I(PAE_I), .PAGING_I(PAGING_I),
    .REQ_VALID_I(REQ_VALID_I), .REQ_WALK_I(REQ_WALK_I), .REQ_ADDR_I(REQ_ADDR_I),
    .FIX_HIT_I(FIX_HIT_I), .OUT_VALID_O(OUT_VALID_O), .OUT_TO_DRAM_O(OUT_TO_DRAM_O),
    .OUT_CRYPT_O(OUT_CRYPT_O), .OUT_KEY_INDEX_O(OUT_KEY_INDEX_O), .OUT_DROP_O(OUT_DROP_O),
    .OUT_FAULT_O(OUT_FAULT_O));
`default_nettype wire

// >>> verification/pare_mem_model.sv
// pare_mem_model.sv: memory controller side, counts accesses routed to dram
// assumes: one routed request per clock, nothing answered back
`timescale 1ns/1ps
`default_nettype none
module pare_mem_model (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic valid_i,
    input wire logic to_dram_i,
    output logic [15:0] dram_cnt_o
);
    // accept every forwarded dram access, ignore io traffic
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dram_cnt_o <= 16'h0;
        end else if (valid_i && to_dram_i) begin
            dram_cnt_o <= dram_cnt_o + 16'h1;
        end
    end
endmodule
`default_nettype wire

// >>> verification/testbench.sv
// testbench.sv: directed checks of routing, cipher and key index outputs
// assumes: pare_top and pare_mem_model compiled before it
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 1'b0, nrst = 1'b0, we = 1'b0, va = 1'b0, wr = 1'b0, wk = 1'b0, en = 1'b0;
    logic pae = 1'b1, hit = 1'b0, frd = 1'b0, v, d, c, dr, f, nd, co, ow;
    logic [1:0] sel = 2'h3;
    logic [63:0] wd = 64'h0, ra = 64'h0, rd;
    logic [3:0] ki;
    logic [51:0] oa;
    logic [4:0] ty;
    logic [31:0] ky;
    logic [15:0] dn;
    int num_errors = 0, num_checks = 0, cyc = 0;
    pare_top pare_top_inst (.MCLK_I(clk), .NRST_I(nrst), .CFG_WE_I(we), .CFG_SEL_I(sel),
        .CFG_WDATA_I(wd), .CFG_RDATA_O(rd), .PAE_I(pae), .PAGING_I(1'b1), .REQ_VALID_I(va),
        .REQ_WRITE_I(wr), .REQ_WALK_I(wk), .REQ_ENC_I(en), .REQ_ADDR_I(ra), .MTYPE_I(3'h0),
        .FIX_RD_MEM_I(frd), .FIX_WR_MEM_I(1'b0), .FIX_HIT_I(hit), .OUT_VALID_O(v),
        .OUT_WRITE_O(ow), .OUT_TO_DRAM_O(d), .OUT_CRYPT_O(c), .OUT_KEY_INDEX_O(ki),
        .OUT_ADDR_O(oa), .OUT_TYPE_O(ty), .OUT_DROP_O(dr), .OUT_FAULT_O(f),
        .OUT_NEXT_DECRYPT_O(nd), .OUT_KEY_O(ky), .COHERENT_O(co));
    pare_mem_model pare_mem_model_inst (.clk_i(clk), .nrst_i(nrst), .valid_i(v),
        .to_dram_i(d), .dram_cnt_o(dn));
    initial begin
        forever #20 clk = ~clk;
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // config write: one cycle strobe
    task automatic cw(input logic [1:0] s, input logic [63:0] dt);
        @(posedge clk);
        we <= 1'b1;
        sel <= s;
        wd <= dt;
        @(posedge clk);
        we <= 1'b0;
    endtask
    // config read: data one cycle after select
    task automatic cr(input logic [1:0] s, input logic [63:0] exp);
        @(posedge clk);
        sel <= s;
        @(posedge clk);
        @(negedge clk);
        chk(rd, exp);
    endtask
    // request {write,walk,enc}; status {valid,dram,crypt,drop,fault} masked
    task automatic rq(input logic [63:0] a, input logic [2:0] m, input logic [4:0] msk, exp);
        @(posedge clk);
        va <= 1'b1;
        ra <= a;
        {wr, wk, en} <= m;
        @(posedge clk);
        va <= 1'b0;
        @(negedge clk);
        chk({59'h0, {v, d, c, dr, f} & msk}, {59'h0, exp});
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            num_errors++;
            report_and_stop();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        cr(2'h2, 64'h0);
        cw(2'h0, 64'h8000_0000_407F_FFFF);
        cw(2'h1, 64'h0000_0002_0000_0000);
        cr(2'h0, 64'h8000_0000_407F_FFFF);
        cr(2'h3, 64'h0);
        rq(64'h1000, 3'h0, 5'h18, 5'h10);
        cw(2'h2, 64'h0030_0000);
        rq(64'h3F80_0000, 3'h1, 5'h1C, 5'h18);
        chk({32'h0, ky}, 64'h0);
        rq(64'h4000_0000, 3'h0, 5'h18, 5'h10);
        rq(64'h0001_0000_0000, 3'h0, 5'h18, 5'h18);
        rq(64'h0002_0000_0000, 3'h0, 5'h18, 5'h10);
        cw(2'h2, 64'h0010_0000);
        rq(64'h0001_0000_0000, 3'h0, 5'h18, 5'h10);
        cw(2'h2, 64'h0030_0000);
        hit <= 1'b1;
        frd <= 1'b1;
        rq(64'h4000_0000, 3'h0, 5'h18, 5'h18);
        chk({59'h0, ty}, 64'h10);
        rq(64'h4000_0000, 3'h4, 5'h18, 5'h10);
        chk({63'h0, ow}, 64'h1);
        chk({59'h0, ty}, 64'h10);
        @(posedge clk);
        hit <= 1'b0;
        cw(2'h2, 64'h00B0_0000);
        rq(64'h1000, 3'h1, 5'h1E, 5'h1C);
        chk({63'h0, ky != 32'h0}, 64'h1);
        cr(2'h3, 64'h0);
        rq(64'h4000_0000, 3'h1, 5'h12, 5'h02);
        rq(64'h1000, 3'h3, 5'h18, 5'h18);
        chk({63'h0, nd}, 64'h1);
        // walk with encrypt attribute clear: fetched without cipher, next table not decrypted
        rq(64'h2000, 3'h2, 5'h1C, 5'h18);
        chk({63'h0, nd}, 64'h0);
        rq(64'h0000_1000_0000_1000, 3'h2, 5'h11, 5'h01);
        rq(64'h0000_8000_0000_1000, 3'h1, 5'h18, 5'h18);
        chk({12'h0, oa}, 64'h1000);
        @(posedge clk);
        pae <= 1'b0;
        rq(64'h1000, 3'h1, 5'h04, 5'h00);
        @(posedge clk);
        pae <= 1'b1;
        cw(2'h2, 64'h0430_0000);
        rq(64'h0000_3000_0000_1000, 3'h0, 5'h1C, 5'h1C);
        chk({60'h0, ki}, 64'h3);
        rq(64'h1000, 3'h0, 5'h1C, 5'h18);
        chk({63'h0, co}, 64'h0);
        @(negedge clk);
        chk({48'h0, dn}, 64'hA);
        report_and_stop();
    end
endmodule
`default_nettype wire
